// *** shared/pin_mux_pkg.sv ***
// package of constants for the pin function and wake-up controller
package pin_mux_pkg;
  // =====================================================
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] ADDR_DIR6 = 8'h00;
  localparam logic [7:0] ADDR_DIR7 = 8'h01;
  localparam logic [7:0] ADDR_DIR8 = 8'h02;
  localparam logic [7:0] ADDR_OUT6 = 8'h03;
  localparam logic [7:0] ADDR_OUT7 = 8'h04;
  localparam logic [7:0] ADDR_OUT8 = 8'h05;
  localparam logic [7:0] ADDR_IN6 = 8'h06;
  localparam logic [7:0] ADDR_IN7 = 8'h07;
  localparam logic [7:0] ADDR_IN8 = 8'h08;
  localparam logic [7:0] ADDR_WAKE6 = 8'h09;
  localparam logic [7:0] ADDR_WAKE7 = 8'h0A;
  localparam logic [7:0] ADDR_WAKE8 = 8'h0B;
  localparam logic [7:0] ADDR_PULLUP6 = 8'h0C;
  localparam logic [7:0] ADDR_PULLDN6 = 8'h0D;
  localparam logic [7:0] ADDR_ODRAIN6 = 8'h0E;
  localparam logic [7:0] ADDR_PULLUP8 = 8'h0F;
  localparam logic [7:0] ADDR_LCD7 = 8'h10;
  localparam logic [7:0] ADDR_LCD8 = 8'h11;
  localparam logic [7:0] ADDR_FUNC = 8'h12;
  localparam logic [7:0] ADDR_CTR_CTRL = 8'h13;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h15;
  // =====================================================
  // field positions
  localparam int FUNC_IRQ_A = 0;
  localparam int FUNC_IRQ_B = 1;
  localparam int FUNC_CTR = 2;
  localparam int FUNC_IR = 3;
  localparam int EDGE_BIT = 7;
  localparam int ST_IRQ_A = 0;
  localparam int ST_IRQ_B = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_BITS = 3;
  // =====================================================
  // values after reset: every option disabled
  localparam logic [7:0] RESET_OFF = 8'h00;
  localparam logic [7:0] RESET_DIR = 8'hFF;
  // power modes
  typedef enum logic [1:0] {
    mode_normal,
    mode_green,
    mode_idle,
    mode_sleep
  } power_mode_e;
endpackage

// *** src/pin_sync.sv ***
// two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // =====================================================
  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

// *** src/pin_function_wakeup_ctrl.sv ***
// pin function multiplexing and pin-change wake-up controller
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Operation
// [R1] Bit 7 of the counter control register picks the edge of ext_irq_a.
// [R2] The ext_irq_b request rises only on a falling edge of its pin.
// [R3] A level change on either external interrupt pin wakes Sleep/Idle.
// [R4] A level change on any port six, seven or eight pin wakes Sleep/Idle.
// [R5] Port six pins offer pull-high, pull-down and open-drain options.
// [R6] Port eight pins offer a pull-high option.
// [R7] The block stays in reset while the active-low reset is held low.
// [R8] General output, counter and interrupt pins have wake forced off; here the interrupt pins wake while their function is selected.
// [R9] LCD pins force off input, wake and pulls but keep open-drain.
// [R10] All software pin options reset to disabled.
// [R11] The shared counter pin, when selected, clocks the counter input.
// [R12] The IR/PWM output drives the shared infrared pin when selected.
// [R13] The shared counter pin works in Normal, Green and Idle only.
// [R14] Pin ownership: analog, then digital out, digital in, general I/O.
// [R15] Software disables wake on pins serving another function.
// [R16] All enabled wake sources merge into one wake request.
module pin_function_wakeup_ctrl
  import pin_mux_pkg::*;
#(
  parameter int P6_W = 8,
  parameter int P7_W = 8,
  parameter int P8_W = 5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] power_mode,
  input wire logic infrared_pwm_out,
  input wire logic ext_irq_a_in,
  input wire logic ext_irq_b_in,
  input wire logic shared_counter_in,
  input wire logic [P6_W-1:0] port_six_in,
  output logic [P6_W-1:0] port_six_out,
  output logic [P6_W-1:0] port_six_oe_b,
  output logic [P6_W-1:0] port_six_pullup,
  output logic [P6_W-1:0] port_six_pulldown,
  input wire logic [P7_W-1:0] port_seven_in,
  output logic [P7_W-1:0] port_seven_out,
  output logic [P7_W-1:0] port_seven_oe_b,
  input wire logic [P8_W-1:0] port_eight_in,
  output logic [P8_W-1:0] port_eight_out,
  output logic [P8_W-1:0] port_eight_oe_b,
  output logic [P8_W-1:0] port_eight_pullup,
  output logic [P7_W-1:0] lcd_seg_sel7,
  output logic [P8_W-1:0] lcd_seg_sel8,
  output logic shared_infrared_out,
  output logic shared_infrared_oe_b,
  output logic rtc_counter_input,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic wake_req,
  output logic irq
);
  localparam int SYNC_W = P6_W + P7_W + P8_W + 3;

  // =====================================================
  // software state
  logic [P6_W-1:0] dir6, out6, wake6, pu6, pd6, od6;
  logic [P7_W-1:0] dir7, out7, wake7, lcd7;
  logic [P8_W-1:0] dir8, out8, wake8, pu8, lcd8;
  logic [3:0] func;
  logic [7:0] ctr_ctrl;
  logic [ST_BITS-1:0] status, mask;
  logic [P6_W-1:0] next_dir6, next_out6, next_wake6;
  logic [P6_W-1:0] next_pu6, next_pd6, next_od6;
  logic [P7_W-1:0] next_dir7, next_out7, next_wake7, next_lcd7;
  logic [P8_W-1:0] next_dir8, next_out8, next_wake8, next_pu8;
  logic [P8_W-1:0] next_lcd8;
  logic [3:0] next_func;
  logic [7:0] next_ctr_ctrl, next_rdata;
  logic [ST_BITS-1:0] next_status, next_mask;
  // pin sample state
  logic [SYNC_W-1:0] sync_now, sync_prev;
  logic [P6_W-1:0] s6;
  logic [P7_W-1:0] s7;
  logic [P8_W-1:0] s8;
  logic sa, sb, sc, pa, pb;
  logic edge_a, edge_b, wake_any, sleeping;
  logic [ST_BITS-1:0] events;

  // =====================================================
  // synchronise every pin before use
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({shared_counter_in, ext_irq_b_in, ext_irq_a_in,
               port_eight_in, port_seven_in, port_six_in}),
    .sync_out(sync_now)
  );

  assign {sc, sb, sa, s8, s7, s6} = sync_now;
  assign pb = sync_prev[SYNC_W-2];
  assign pa = sync_prev[SYNC_W-3];
  assign sleeping = (power_mode == mode_sleep);

  // returns one bit, set when any enabled wake source changed
  function automatic logic any_change(input logic [SYNC_W-1:0] a,
                                      input logic [SYNC_W-1:0] b,
                                      input logic [SYNC_W-1:0] en);
    any_change = |((a ^ b) & en);
  endfunction

  // =====================================================
  // pin drive and function ownership
  always_comb begin
    // [R14] lcd (analog) wins over output, then general I/O
    // [R9] lcd pins release drive and pulls
    port_seven_out = out7;
    port_seven_oe_b = dir7 | lcd7;
    lcd_seg_sel7 = lcd7;
    port_eight_out = out8;
    port_eight_oe_b = dir8 | lcd8;
    lcd_seg_sel8 = lcd8;
    // [R6] port eight pull-high, off on lcd pins
    port_eight_pullup = pu8 & ~lcd8;
    // [R5] port six pulls and open-drain, oe low drives
    port_six_out = out6;
    port_six_oe_b = dir6 | (od6 & out6);
    port_six_pullup = pu6;
    port_six_pulldown = pd6;
    // [R12] infrared output owns its pin when selected
    shared_infrared_out = infrared_pwm_out;
    shared_infrared_oe_b = ~func[FUNC_IR];
  end

  // =====================================================
  // edge detection and wake combining
  always_comb begin
    // [R1] polarity from counter control bit 7
    if (ctr_ctrl[EDGE_BIT]) begin
      edge_a = sa & ~pa;
    end else begin
      edge_a = ~sa & pa;
    end
    // [R2] falling edge only
    edge_b = ~sb & pb;
    // [R8] wake off on output, lcd and counter pins (R9 too)
    // [R4] port pin changes, [R3] interrupt pin changes
    wake_any = any_change(sync_now, sync_prev,
      {1'b0, func[FUNC_IRQ_B], func[FUNC_IRQ_A],
       wake8 & dir8 & ~lcd8, wake7 & dir7 & ~lcd7, wake6 & dir6});
    events = '0;
    events[ST_IRQ_A] = edge_a & func[FUNC_IRQ_A];
    events[ST_IRQ_B] = edge_b & func[FUNC_IRQ_B];
    events[ST_WAKE] = wake_any;
  end

  // [R11] counter pin routed in, [R13] gated off in sleep
  assign rtc_counter_input = sc & func[FUNC_CTR] & ~sleeping;

  // =====================================================
  // register next-state logic
  always_comb begin
    next_dir6 = dir6;
    next_out6 = out6;
    next_wake6 = wake6;
    next_pu6 = pu6;
    next_pd6 = pd6;
    next_od6 = od6;
    next_dir7 = dir7;
    next_out7 = out7;
    next_wake7 = wake7;
    next_lcd7 = lcd7;
    next_dir8 = dir8;
    next_out8 = out8;
    next_wake8 = wake8;
    next_pu8 = pu8;
    next_lcd8 = lcd8;
    next_func = func;
    next_ctr_ctrl = ctr_ctrl;
    next_mask = mask;
    next_status = status;
    next_rdata = 8'h00;
    if (reg_wr) begin
      if (reg_addr == ADDR_DIR6) begin
        next_dir6 = reg_wdata[P6_W-1:0];
      end else if (reg_addr == ADDR_DIR7) begin
        next_dir7 = reg_wdata[P7_W-1:0];
      end else if (reg_addr == ADDR_DIR8) begin
        next_dir8 = reg_wdata[P8_W-1:0];
      end else if (reg_addr == ADDR_OUT6) begin
        next_out6 = reg_wdata[P6_W-1:0];
      end else if (reg_addr == ADDR_OUT7) begin
        next_out7 = reg_wdata[P7_W-1:0];
      end else if (reg_addr == ADDR_OUT8) begin
        next_out8 = reg_wdata[P8_W-1:0];
      end else if (reg_addr == ADDR_WAKE6) begin
        next_wake6 = reg_wdata[P6_W-1:0];
      end else if (reg_addr == ADDR_WAKE7) begin
        next_wake7 = reg_wdata[P7_W-1:0];
      end else if (reg_addr == ADDR_WAKE8) begin
        next_wake8 = reg_wdata[P8_W-1:0];
      end else if (reg_addr == ADDR_PULLUP6) begin
        next_pu6 = reg_wdata[P6_W-1:0];
      end else if (reg_addr == ADDR_PULLDN6) begin
        next_pd6 = reg_wdata[P6_W-1:0];
      end else if (reg_addr == ADDR_ODRAIN6) begin
        next_od6 = reg_wdata[P6_W-1:0];
      end else if (reg_addr == ADDR_PULLUP8) begin
        next_pu8 = reg_wdata[P8_W-1:0];
      end else if (reg_addr == ADDR_LCD7) begin
        next_lcd7 = reg_wdata[P7_W-1:0];
      end else if (reg_addr == ADDR_LCD8) begin
        next_lcd8 = reg_wdata[P8_W-1:0];
      end else if (reg_addr == ADDR_FUNC) begin
        next_func = reg_wdata[3:0];
      end else if (reg_addr == ADDR_CTR_CTRL) begin
        next_ctr_ctrl = reg_wdata;
      end else if (reg_addr == ADDR_STATUS) begin
        next_status = status & ~reg_wdata[ST_BITS-1:0];
      end else if (reg_addr == ADDR_MASK) begin
        next_mask = reg_wdata[ST_BITS-1:0];
      end
    end
    // set wins over a same-cycle clear
    next_status = next_status | events;
    if (reg_rd) begin
      if (reg_addr == ADDR_DIR6) begin
        next_rdata = 8'(dir6);
      end else if (reg_addr == ADDR_DIR7) begin
        next_rdata = 8'(dir7);
      end else if (reg_addr == ADDR_DIR8) begin
        next_rdata = 8'(dir8);
      end else if (reg_addr == ADDR_OUT6) begin
        next_rdata = 8'(out6);
      end else if (reg_addr == ADDR_OUT7) begin
        next_rdata = 8'(out7);
      end else if (reg_addr == ADDR_OUT8) begin
        next_rdata = 8'(out8);
      end else if (reg_addr == ADDR_IN6) begin
        next_rdata = 8'(s6);
      end else if (reg_addr == ADDR_IN7) begin
        // [R9] lcd pins read back zero
        next_rdata = 8'(s7 & ~lcd7);
      end else if (reg_addr == ADDR_IN8) begin
        next_rdata = 8'(s8 & ~lcd8);
      end else if (reg_addr == ADDR_WAKE6) begin
        next_rdata = 8'(wake6);
      end else if (reg_addr == ADDR_WAKE7) begin
        next_rdata = 8'(wake7);
      end else if (reg_addr == ADDR_WAKE8) begin
        next_rdata = 8'(wake8);
      end else if (reg_addr == ADDR_PULLUP6) begin
        next_rdata = 8'(pu6);
      end else if (reg_addr == ADDR_PULLDN6) begin
        next_rdata = 8'(pd6);
      end else if (reg_addr == ADDR_ODRAIN6) begin
        next_rdata = 8'(od6);
      end else if (reg_addr == ADDR_PULLUP8) begin
        next_rdata = 8'(pu8);
      end else if (reg_addr == ADDR_LCD7) begin
        next_rdata = 8'(lcd7);
      end else if (reg_addr == ADDR_LCD8) begin
        next_rdata = 8'(lcd8);
      end else if (reg_addr == ADDR_FUNC) begin
        next_rdata = 8'(func);
      end else if (reg_addr == ADDR_CTR_CTRL) begin
        next_rdata = ctr_ctrl;
      end else if (reg_addr == ADDR_STATUS) begin
        next_rdata = 8'(status);
      end else if (reg_addr == ADDR_MASK) begin
        next_rdata = 8'(mask);
      end
    end
  end

  // =====================================================
  // registers; [R7] held in reset while rst_b is low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // [R10] all options disabled, pins as inputs
      dir6 <= P6_W'(RESET_DIR);
      dir7 <= P7_W'(RESET_DIR);
      dir8 <= P8_W'(RESET_DIR);
      out6 <= P6_W'(RESET_OFF);
      out7 <= P7_W'(RESET_OFF);
      out8 <= P8_W'(RESET_OFF);
      wake6 <= P6_W'(RESET_OFF);
      wake7 <= P7_W'(RESET_OFF);
      wake8 <= P8_W'(RESET_OFF);
      pu6 <= P6_W'(RESET_OFF);
      pd6 <= P6_W'(RESET_OFF);
      od6 <= P6_W'(RESET_OFF);
      pu8 <= P8_W'(RESET_OFF);
      lcd7 <= P7_W'(RESET_OFF);
      lcd8 <= P8_W'(RESET_OFF);
      func <= RESET_OFF[3:0];
      ctr_ctrl <= RESET_OFF;
      status <= RESET_OFF[ST_BITS-1:0];
      mask <= RESET_OFF[ST_BITS-1:0];
      reg_rdata <= RESET_OFF;
      sync_prev <= '0;
      ext_irq_a <= 1'b0;
      ext_irq_b <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      dir6 <= next_dir6;
      dir7 <= next_dir7;
      dir8 <= next_dir8;
      out6 <= next_out6;
      out7 <= next_out7;
      out8 <= next_out8;
      wake6 <= next_wake6;
      wake7 <= next_wake7;
      wake8 <= next_wake8;
      pu6 <= next_pu6;
      pd6 <= next_pd6;
      od6 <= next_od6;
      pu8 <= next_pu8;
      lcd7 <= next_lcd7;
      lcd8 <= next_lcd8;
      func <= next_func;
      ctr_ctrl <= next_ctr_ctrl;
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
      sync_prev <= sync_now;
      ext_irq_a <= events[ST_IRQ_A];
      ext_irq_b <= events[ST_IRQ_B];
      // [R16] one merged wake pulse
      wake_req <= wake_any;
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(status & mask);
endmodule

// *** bench/pin_mux_monitor.sv ***
// checker on the ports of the pin function and wake-up controller
`timescale 1ns/10ps
module pin_mux_monitor
  import pin_mux_pkg::*;
#(
  parameter int P6_W = 8,
  parameter int P7_W = 8,
  parameter int P8_W = 5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] power_mode,
  input wire logic infrared_pwm_out,
  input wire logic ext_irq_a_in,
  input wire logic ext_irq_b_in,
  input wire logic shared_counter_in,
  input wire logic [P6_W-1:0] port_six_in,
  input wire logic [P7_W-1:0] port_seven_in,
  input wire logic [P8_W-1:0] port_eight_in,
  input wire logic [P6_W-1:0] port_six_oe_b,
  input wire logic [P6_W-1:0] port_six_pullup,
  input wire logic [P8_W-1:0] port_eight_pullup,
  input wire logic [P8_W-1:0] lcd_seg_sel8,
  input wire logic shared_infrared_out,
  input wire logic shared_infrared_oe_b,
  input wire logic rtc_counter_input,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic wake_req
);
  // ==================================================
  // every pin that may cause a wake pulse
  logic [P6_W+P7_W+P8_W+1:0] pins;
  assign pins = {port_six_in, port_seven_in, port_eight_in, ext_irq_a_in,
    ext_irq_b_in};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // ==================================================
  // pin events: two sync flops plus the edge register put the cause
  // between the samples taken 4 and 3 edges back
  a_reset_opts_off: assert property (
    $rose(rst_b) |-> &port_six_oe_b && port_six_pullup == '0
      && port_eight_pullup == '0) else $error("options on after reset");
  a_lcd_no_pull: assert property (
    (lcd_seg_sel8 & port_eight_pullup) == '0) else $error("lcd pin pulled");
  a_ir_route: assert property (
    !shared_infrared_oe_b |-> shared_infrared_out == infrared_pwm_out)
    else $error("ir pin not following generator");
  a_counter_sleep: assert property (
    power_mode == mode_sleep |-> !rtc_counter_input)
    else $error("counter input active in sleep");
  a_counter_src: assert property (
    rtc_counter_input |-> $past(shared_counter_in, 2)
      || $past(shared_counter_in, 3)) else $error("counter input unsourced");
  a_irq_b_fall: assert property (
    ext_irq_b |-> !$past(ext_irq_b_in, 3) && $past(ext_irq_b_in, 4))
    else $error("irq b pulse without falling edge");
  a_irq_a_edge: assert property (
    ext_irq_a |-> $past(ext_irq_a_in, 3) != $past(ext_irq_a_in, 4))
    else $error("irq a pulse without edge");
  a_wake_cause: assert property (
    wake_req |-> $past(pins, 3) != $past(pins, 4))
    else $error("wake pulse without pin change");
  // main scenarios reached
  c_irq_a: cover property (ext_irq_a);
  c_wake: cover property (wake_req && power_mode == mode_sleep);
  c_counter: cover property (rtc_counter_input && power_mode == mode_idle);
  c_ir: cover property (!shared_infrared_oe_b && infrared_pwm_out);
endmodule
bind pin_function_wakeup_ctrl pin_mux_monitor #(
  .P6_W(P6_W), .P7_W(P7_W), .P8_W(P8_W)
) chk (.core_clk, .rst_b, .power_mode, .infrared_pwm_out, .ext_irq_a_in,
  .ext_irq_b_in, .shared_counter_in, .port_six_in, .port_seven_in,
  .port_eight_in, .port_six_oe_b, .port_six_pullup, .port_eight_pullup,
  .lcd_seg_sel8, .shared_infrared_out, .shared_infrared_oe_b,
  .rtc_counter_input, .ext_irq_a, .ext_irq_b, .wake_req);

// *** bench/pin_world.sv ***
// board model: switch, pull resistor and chip drive on one port
`timescale 1ns/10ps
module pin_world #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe_b,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] pd,
  input wire logic [W-1:0] sw,
  input wire logic [W-1:0] sw_en,
  output logic [W-1:0] lvl
);
  logic [W-1:0] last;
  // ==================================================
  // a floating pin toggles so a missing drive never looks stable
  always_ff @(posedge core_clk) begin
    last <= lvl;
  end
  // chip drive wins, then a closed switch, then the pulls
  always_comb begin
    lvl = ~last;
    for (int i = 0; i < W; i++) begin
      if (!oe_b[i]) begin
        lvl[i] = drv[i];
      end else if (sw_en[i]) begin
        lvl[i] = sw[i];
      end else if (pu[i] || pd[i]) begin
        lvl[i] = pu[i];
      end
    end
  end
endmodule

// *** bench/test_pin_function_wakeup_ctrl.sv ***
// self-checking bench for the pin function and wake-up controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
  end \
end
module test_pin_function_wakeup_ctrl;
  import pin_mux_pkg::*;
  // ==================================================
  // signals
  logic core_clk, rst_b, reg_wr, reg_rd, infrared_pwm_out, ext_irq_a_in;
  logic ext_irq_b_in, shared_counter_in, shared_infrared_out, irq;
  logic shared_infrared_oe_b, rtc_counter_input, ext_irq_a, ext_irq_b;
  logic wake_req;
  logic [1:0] power_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_six_out, port_six_oe_b;
  logic [7:0] port_six_pullup, port_six_pulldown, port_seven_out;
  logic [7:0] port_seven_oe_b, lcd_seg_sel7;
  logic [4:0] port_eight_out, port_eight_oe_b, port_eight_pullup;
  logic [4:0] lcd_seg_sel8;
  wire logic [7:0] port_six_in, port_seven_in;
  wire logic [4:0] port_eight_in;
  logic [20:0] sw, sw_en;
  logic [31:0] seed;
  int na, nb, nw, cyc, n_errors, checked;
  // ==================================================
  // design and board
  pin_function_wakeup_ctrl uut (.core_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .power_mode, .infrared_pwm_out,
    .ext_irq_a_in, .ext_irq_b_in, .shared_counter_in, .port_six_in,
    .port_six_out, .port_six_oe_b, .port_six_pullup, .port_six_pulldown,
    .port_seven_in, .port_seven_out, .port_seven_oe_b, .port_eight_in,
    .port_eight_out, .port_eight_oe_b, .port_eight_pullup, .lcd_seg_sel7,
    .lcd_seg_sel8, .shared_infrared_out, .shared_infrared_oe_b,
    .rtc_counter_input, .ext_irq_a, .ext_irq_b, .wake_req, .irq);
  pin_world #(.W(8)) board6 (.core_clk, .drv(port_six_out),
    .oe_b(port_six_oe_b), .pu(port_six_pullup), .pd(port_six_pulldown),
    .sw(sw[7:0]), .sw_en(sw_en[7:0]), .lvl(port_six_in));
  pin_world #(.W(8)) board7 (.core_clk, .drv(port_seven_out),
    .oe_b(port_seven_oe_b), .pu(8'h00), .pd(8'h00), .sw(sw[15:8]),
    .sw_en(sw_en[15:8]), .lvl(port_seven_in));
  pin_world #(.W(5)) board8 (.core_clk, .drv(port_eight_out),
    .oe_b(port_eight_oe_b), .pu(port_eight_pullup), .pd(5'h00),
    .sw(sw[20:16]), .sw_en(sw_en[20:16]), .lvl(port_eight_in));
  // ==================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  // drive pins, then count pulses over a window longer than sync delay
  task ev(input logic a, input logic b, input logic [20:0] sv,
      input int ea, input int eb, input int ew);
    int a0, b0, w0;
    a0 = na;
    b0 = nb;
    w0 = nw;
    @(posedge core_clk);
    ext_irq_a_in <= a;
    ext_irq_b_in <= b;
    sw <= sv;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("irq a pulses", ea, na - a0)
    `CHK("irq b pulses", eb, nb - b0)
    `CHK("wake pulses", ew, nw - w0)
  endtask
  task end_of_test;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==================================================
  // clock, pulse counters and hang guard
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    // an unknown pulse counts too, so it cannot hide
    if (ext_irq_a !== 1'b0) na++;
    if (ext_irq_b !== 1'b0) nb++;
    if (wake_req !== 1'b0) nw++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    power_mode = 2'h0;
    infrared_pwm_out = 1'b0;
    ext_irq_a_in = 1'b1;
    ext_irq_b_in = 1'b1;
    shared_counter_in = 1'b0;
    sw = 21'h15A5A5;
    sw_en = 21'h1FFFFF;
    seed = 32'h11CD;
    repeat (6) @(posedge core_clk);
    `CHK("oe six in reset", 8'hFF, port_six_oe_b)
    rst_b <= 1'b1;
    for (int a = 0; a < 22; a++) begin
      if (a < 6 || a > 8) begin
        rdc(a[7:0], a < 2 ? 8'hFF : (a == 2 ? 8'h1F : 8'h00));
      end
    end
    wr(8'h20, 8'hFF);
    rdc(8'h20, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_PULLUP6, seed[7:0]);
      wr(ADDR_PULLDN6, seed[15:8]);
      wr(ADDR_PULLUP8, seed[23:16]);
      `CHK("pullup six", seed[7:0], port_six_pullup)
      `CHK("pulldown six", seed[15:8], port_six_pulldown)
      `CHK("pullup eight", seed[20:16], port_eight_pullup)
      rdc(ADDR_PULLUP8, {3'h0, seed[20:16]});
    end
    // switches open: each pin rests at its pull level
    wr(ADDR_PULLDN6, ~seed[7:0]);
    @(posedge core_clk);
    sw_en[7:0] <= 8'h00;
    repeat (3) @(posedge core_clk);
    rdc(ADDR_IN6, seed[7:0]);
    @(posedge core_clk);
    sw_en[7:0] <= 8'hFF;
    // open drain releases the ones, push-pull drives all
    wr(ADDR_ODRAIN6, 8'hFF);
    wr(ADDR_OUT6, 8'h0F);
    wr(ADDR_DIR6, 8'h00);
    `CHK("open drain oe", 8'h0F, port_six_oe_b)
    `CHK("out six", 8'h0F, port_six_out)
    repeat (2) @(posedge core_clk);
    rdc(ADDR_IN6, {4'h0, sw[3:0]});
    wr(ADDR_ODRAIN6, 8'h00);
    `CHK("push pull oe", 8'h00, port_six_oe_b)
    wr(ADDR_DIR6, 8'hFF);
    // ports seven and eight drive and read back their own data
    wr(ADDR_OUT7, seed[31:24]);
    wr(ADDR_OUT8, seed[31:24]);
    wr(ADDR_DIR7, 8'h00);
    wr(ADDR_DIR8, 8'h00);
    `CHK("out seven", seed[31:24], port_seven_out)
    `CHK("out eight", seed[28:24], port_eight_out)
    rdc(ADDR_IN7, seed[31:24]);
    rdc(ADDR_IN8, {3'h0, seed[28:24]});
    wr(ADDR_DIR7, 8'hFF);
    wr(ADDR_DIR8, 8'h1F);
    $display("pin option test done");
    @(posedge core_clk);
    power_mode <= mode_idle;
    wr(ADDR_FUNC, 8'h03);
    wr(ADDR_MASK, 8'h07);
    wr(ADDR_CTR_CTRL, 8'h00);
    ev(1'b0, 1'b1, sw, 1, 0, 1);
    ev(1'b1, 1'b1, sw, 0, 0, 1);
    wr(ADDR_CTR_CTRL, 8'h80);
    ev(1'b0, 1'b1, sw, 0, 0, 1);
    ev(1'b1, 1'b1, sw, 1, 0, 1);
    ev(1'b1, 1'b0, sw, 0, 1, 1);
    ev(1'b1, 1'b1, sw, 0, 0, 1);
    rdc(ADDR_STATUS, 8'h07);
    `CHK("irq unmasked", 1'b1, irq)
    wr(ADDR_MASK, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_MASK, 8'h04);
    wr(ADDR_STATUS, 8'h07);
    rdc(ADDR_STATUS, 8'h00);
    `CHK("irq cleared", 1'b0, irq)
    $display("edge and interrupt test done");
    @(posedge core_clk);
    power_mode <= mode_sleep;
    wr(ADDR_WAKE6, 8'hFF);
    wr(ADDR_WAKE7, 8'hFF);
    wr(ADDR_WAKE8, 8'h1F);
    seed = xs(seed);
    ev(1'b1, 1'b1, sw ^ {13'h0000, seed[7:0] | 8'h01}, 0, 0, 1);
    ev(1'b1, 1'b1, sw ^ {5'h00, seed[15:8] | 8'h01, 8'h00}, 0, 0, 1);
    ev(1'b1, 1'b1, sw ^ {seed[20:16] | 5'h01, 16'h0000}, 0, 0, 1);
    // output pins change level but must stay silent
    wr(ADDR_OUT6, ~sw[7:0]);
    wr(ADDR_DIR6, 8'h00);
    ev(1'b1, 1'b1, sw, 0, 0, 0);
    wr(ADDR_LCD7, 8'hFF);
    `CHK("lcd sel seven", 8'hFF, lcd_seg_sel7)
    rdc(ADDR_IN7, 8'h00);
    ev(1'b1, 1'b1, sw ^ {5'h00, 8'hFF, 8'h00}, 0, 0, 0);
    wr(ADDR_PULLUP8, 8'h1F);
    wr(ADDR_LCD8, 8'h1F);
    `CHK("lcd pin pull", 5'h00, port_eight_pullup)
    `CHK("lcd sel eight", 5'h1F, lcd_seg_sel8)
    ev(1'b1, 1'b1, sw ^ {5'h1F, 16'h0000}, 0, 0, 0);
    // lcd pins stay released even when set as outputs
    wr(ADDR_DIR7, 8'h00);
    wr(ADDR_DIR8, 8'h00);
    `CHK("lcd oe seven", 8'hFF, port_seven_oe_b)
    `CHK("lcd oe eight", 5'h1F, port_eight_oe_b)
    // software drops wake on pins it gave to other functions
    wr(ADDR_WAKE7, 8'h00);
    wr(ADDR_WAKE8, 8'h00);
    rdc(ADDR_WAKE7, 8'h00);
    $display("port wake test done");
    wr(ADDR_FUNC, 8'h0C);
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      shared_counter_in <= 1'b1;
      power_mode <= m[1:0];
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("counter input", m != 3, rtc_counter_input)
    end
    @(posedge core_clk);
    power_mode <= mode_normal;
    shared_counter_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("counter low", 1'b0, rtc_counter_input)
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      infrared_pwm_out <= v[0];
      #1;
      `CHK("ir pin", v[0], shared_infrared_out)
      `CHK("ir drive", 1'b0, shared_infrared_oe_b)
    end
    wr(ADDR_FUNC, 8'h00);
    `CHK("ir released", 1'b1, shared_infrared_oe_b)
    $display("counter and infrared test done");
    end_of_test();
  end
endmodule
